// ### tco_pkg.sv
// Package with register map, field layout and types of the channel one compare block.
package tco_pkg;
	localparam logic [7:0] TCO_ADDR_SWEVT = 8'h00;
	localparam logic [7:0] TCO_ADDR_MODE  = 8'h04;
	localparam logic [7:0] TCO_ADDR_POL   = 8'h08;
	localparam logic [7:0] TCO_ADDR_CMP   = 8'h0C;
	localparam logic [7:0] TCO_ADDR_BUF   = 8'h10;
	localparam logic [7:0] TCO_ADDR_STAT  = 8'h14;
	localparam int TCO_BIT_BRK  = 7;
	localparam int TCO_BIT_HALL = 5;
	localparam int TCO_BIT_CH1  = 1;
	localparam int TCO_BIT_OVF  = 0;
	localparam int TCO_OBS_LSB    = 4;
	localparam int TCO_BIT_SHADOW = 3;
	localparam int TCO_BIT_FAST   = 2;
	localparam int TCO_BIT_EN   = 0;
	localparam int TCO_BIT_POL  = 1;
	localparam int TCO_BIT_CEN  = 2;
	localparam int TCO_BIT_CPOL = 3;
	localparam int TCO_BIT_BUFCTL = 0;
	localparam int TCO_NFLAG = 4;
	localparam int TCO_STAT_POS [TCO_NFLAG] = '{0, 1, 5, 7};
	localparam logic [2:0] TCO_OBS_OFF  = 3'h0;
	localparam logic [2:0] TCO_OBS_SET  = 3'h1;
	localparam logic [2:0] TCO_OBS_CLR  = 3'h2;
	localparam logic [2:0] TCO_OBS_TOG  = 3'h3;
	localparam logic [2:0] TCO_OBS_LOW  = 3'h4;
	localparam logic [2:0] TCO_OBS_HIGH = 3'h5;
	localparam logic [2:0] TCO_OBS_PWMA = 3'h6;
	localparam logic [2:0] TCO_OBS_PWMB = 3'h7;
	localparam logic [1:0] TCO_DIR_OUTPUT = 2'h0;
	localparam logic [7:0] TCO_MODE_RST = 8'h00;
	localparam logic [3:0] TCO_POL_RST  = 4'h0;
	localparam logic [15:0] TCO_CMP_RST = 16'h0000;
	typedef struct packed {
		logic       en;
		logic       comp_en;
		logic [2:0] obs;
	} tco_ctl_t;
	localparam tco_ctl_t TCO_CTL_RST = '{en: 1'b0, comp_en: 1'b0, obs: 3'h0};
	typedef enum logic [1:0] {
		TCO_ST_SETUP  = 2'b01,
		TCO_ST_ANSWER = 2'b10
	} tco_apb_st_t;
endpackage

// ### tco_channel.sv
// Channel one software events, output compare and APB register file.
`timescale 1ns/100ps
module tco_channel (
	input  wire logic        i_clk_sys,
	input  wire logic        i_resetn,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic [15:0] i_counter_value,
	input  wire logic        i_count_direction,
	input  wire logic        i_overflow_event,
	input  wire logic        i_trigger_event,
	output logic             o_channel_one_output,
	output logic             o_channel_one_comp_output,
	output logic             o_raw_compare_signal,
	output logic             o_break_event,
	output logic             o_hall_event,
	output logic             o_overflow_event,
	output logic             o_channel_one_event
);
	tco_pkg::tco_apb_st_t st_reg;
	tco_pkg::tco_apb_st_t st_next;
	tco_pkg::tco_ctl_t    ctl_reg;
	tco_pkg::tco_ctl_t    ctl_pre;
	tco_pkg::tco_ctl_t    ctl_next;
	logic [7:0]  mode_reg;
	logic [3:0]  pol_reg;
	logic        bufctl_reg;
	logic [15:0] cmp_buf_reg;
	logic [15:0] cmp_act_reg;
	logic [15:0] cmp_act_next;
	logic [tco_pkg::TCO_NFLAG-1:0] flag_reg;
	logic [tco_pkg::TCO_NFLAG-1:0] flag_next;
	logic        raw_reg;
	logic        raw_next;
	logic        out_reg;
	logic        cout_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;
	logic [31:0] rdata;
	logic [31:0] stat_word;

	wire take      = i_psel & i_penable & (st_reg == tco_pkg::TCO_ST_SETUP);
	wire done      = i_psel & i_penable & (st_reg == tco_pkg::TCO_ST_ANSWER);
	wire wr        = done & i_pwrite;
	wire sel_swevt = i_paddr == tco_pkg::TCO_ADDR_SWEVT;
	wire sel_mode  = i_paddr == tco_pkg::TCO_ADDR_MODE;
	wire sel_pol   = i_paddr == tco_pkg::TCO_ADDR_POL;
	wire sel_cmp   = i_paddr == tco_pkg::TCO_ADDR_CMP;
	wire sel_buf   = i_paddr == tco_pkg::TCO_ADDR_BUF;
	wire sel_stat  = i_paddr == tco_pkg::TCO_ADDR_STAT;
	wire mapped    = sel_swevt | sel_mode | sel_pol | sel_cmp | sel_buf | sel_stat;

	// Trigger bits are never stored, so each write yields a single cycle strobe.
	wire sw_break_trigger       = wr & sel_swevt & i_pwdata[tco_pkg::TCO_BIT_BRK];
	wire sw_commutation_trigger = wr & sel_swevt & i_pwdata[tco_pkg::TCO_BIT_HALL];
	wire sw_channel_one_trigger = wr & sel_swevt & i_pwdata[tco_pkg::TCO_BIT_CH1];
	wire sw_overflow_trigger    = wr & sel_swevt & i_pwdata[tco_pkg::TCO_BIT_OVF];

	wire [2:0] output_behaviour_select = mode_reg[tco_pkg::TCO_OBS_LSB +: 3];
	wire       compare_shadow_enable   = mode_reg[tco_pkg::TCO_BIT_SHADOW];
	wire       fast_output_enable      = mode_reg[tco_pkg::TCO_BIT_FAST];
	wire [1:0] channel_direction_select = mode_reg[1:0];
	wire       out_mode = channel_direction_select == tco_pkg::TCO_DIR_OUTPUT;
	wire       pol      = pol_reg[tco_pkg::TCO_BIT_POL];
	wire       cpol     = pol_reg[tco_pkg::TCO_BIT_CPOL];

	wire hall_evt  = sw_commutation_trigger;
	wire ovf_evt   = i_overflow_event | sw_overflow_trigger;
	wire match     = out_mode & (i_counter_value == cmp_act_reg);
	wire ch1_evt   = sw_channel_one_trigger | match;
	wire cmp_write = wr & sel_cmp;
	wire stat_wr   = wr & sel_stat;
	wire is_pwm    = (ctl_reg.obs == tco_pkg::TCO_OBS_PWMA) | (ctl_reg.obs == tco_pkg::TCO_OBS_PWMB);
	wire fast_hit  = is_pwm & fast_output_enable & i_trigger_event;
	wire cmp_above = cmp_act_reg > i_counter_value;
	wire cmp_below = cmp_act_reg < i_counter_value;
	wire pwm_a     = i_count_direction ? ~cmp_below : cmp_above;
	localparam int TCO_NFLAG_W = tco_pkg::TCO_NFLAG;
	wire [TCO_NFLAG_W-1:0] flag_set = {sw_break_trigger, hall_evt, ch1_evt, ovf_evt};

	assign ctl_pre.en      = pol_reg[tco_pkg::TCO_BIT_EN];
	assign ctl_pre.comp_en = pol_reg[tco_pkg::TCO_BIT_CEN];
	assign ctl_pre.obs     = output_behaviour_select;
	// Buffered controls wait for a commutation event; unbuffered ones pass at once.
	assign ctl_next = (!bufctl_reg || hall_evt) ? ctl_pre : ctl_reg;

	always_comb begin
		cmp_act_next = cmp_act_reg;
		if (cmp_write && !compare_shadow_enable) begin
			cmp_act_next = i_pwdata[15:0];
		end else if (ovf_evt && compare_shadow_enable) begin
			cmp_act_next = cmp_buf_reg;
		end
	end

	// Raw level only moves while the channel is an output.
	always_comb begin
		raw_next = raw_reg;
		if (out_mode) begin
			case (ctl_reg.obs)
				tco_pkg::TCO_OBS_OFF:  raw_next = raw_reg;
				tco_pkg::TCO_OBS_SET:  raw_next = match ? 1'b1 : raw_reg;
				tco_pkg::TCO_OBS_CLR:  raw_next = match ? 1'b0 : raw_reg;
				tco_pkg::TCO_OBS_TOG:  raw_next = match ? ~raw_reg : raw_reg;
				tco_pkg::TCO_OBS_LOW:  raw_next = 1'b0;
				tco_pkg::TCO_OBS_HIGH: raw_next = 1'b1;
				tco_pkg::TCO_OBS_PWMA: raw_next = fast_hit ? 1'b1 : pwm_a;
				tco_pkg::TCO_OBS_PWMB: raw_next = fast_hit ? 1'b0 : ~pwm_a;
				default:               raw_next = raw_reg;
			endcase
		end
	end

	// Sticky flags: a hardware set wins over a clear written in the same cycle.
	genvar gi;
	generate
		for (gi = 0; gi < TCO_NFLAG_W; gi = gi + 1) begin : g_flag
			wire clr = stat_wr & ~i_pwdata[tco_pkg::TCO_STAT_POS[gi]];
			assign flag_next[gi] = flag_set[gi] | (flag_reg[gi] & ~clr);
			assign stat_word[tco_pkg::TCO_STAT_POS[gi]] = flag_reg[gi];
		end
	endgenerate
	assign stat_word[31:8] = 24'h000000;
	assign stat_word[6]    = 1'b0;
	assign stat_word[4:2]  = 3'h0;

	assign rdata = sel_mode ? {24'h000000, 1'b0, mode_reg[6:0]} :
		sel_pol ? {28'h0000000, pol_reg} :
		sel_cmp ? {16'h0000, cmp_act_reg} :
		sel_buf ? {31'h00000000, bufctl_reg} :
		sel_stat ? stat_word : 32'h00000000;

	assign st_next = take ? tco_pkg::TCO_ST_ANSWER : tco_pkg::TCO_ST_SETUP;

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			st_reg      <= tco_pkg::TCO_ST_SETUP;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			st_reg      <= st_next;
			prdata_reg  <= (take && !i_pwrite && mapped) ? rdata : 32'h00000000;
			pslverr_reg <= take & ~mapped;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			mode_reg   <= tco_pkg::TCO_MODE_RST;
			pol_reg    <= tco_pkg::TCO_POL_RST;
			bufctl_reg <= 1'b0;
		end else begin
			if (wr && sel_mode) begin
				mode_reg <= {1'b0, i_pwdata[6:0]};
			end
			if (wr && sel_pol) begin
				pol_reg <= i_pwdata[3:0];
			end
			if (wr && sel_buf) begin
				bufctl_reg <= i_pwdata[tco_pkg::TCO_BIT_BUFCTL];
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			cmp_buf_reg <= tco_pkg::TCO_CMP_RST;
			cmp_act_reg <= tco_pkg::TCO_CMP_RST;
			ctl_reg     <= tco_pkg::TCO_CTL_RST;
			flag_reg    <= '0;
			raw_reg     <= 1'b0;
		end else begin
			if (cmp_write) begin
				cmp_buf_reg <= i_pwdata[15:0];
			end
			cmp_act_reg <= cmp_act_next;
			ctl_reg     <= ctl_next;
			flag_reg    <= flag_next;
			raw_reg     <= raw_next;
		end
	end

	// Disconnected channel rests at its inactive level; disabled outputs stay low.
	wire obs_off    = ctl_reg.obs == tco_pkg::TCO_OBS_OFF;
	wire out_level  = obs_off ? pol : raw_reg ^ pol;
	wire cout_level = obs_off ? cpol : ~raw_reg ^ cpol;
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			out_reg  <= 1'b0;
			cout_reg <= 1'b0;
		end else begin
			out_reg  <= ctl_reg.en & out_level;
			cout_reg <= ctl_reg.comp_en & cout_level;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_break_event       <= 1'b0;
			o_hall_event        <= 1'b0;
			o_overflow_event    <= 1'b0;
			o_channel_one_event <= 1'b0;
		end else begin
			o_break_event       <= sw_break_trigger;
			o_hall_event        <= hall_evt;
			o_overflow_event    <= ovf_evt;
			o_channel_one_event <= ch1_evt;
		end
	end

	assign o_prdata                  = prdata_reg;
	assign o_pready                  = st_reg[1];
	assign o_pslverr                 = pslverr_reg;
	assign o_raw_compare_signal      = raw_reg;
	assign o_channel_one_output      = out_reg;
	assign o_channel_one_comp_output = cout_reg;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);

	sequence seq_sw_write(int b);
		wr && sel_swevt && i_pwdata[b];
	endsequence

	sequence seq_match_out;
		out_mode && (i_counter_value == cmp_act_reg);
	endsequence

	property p_break_pulse;
		seq_sw_write(tco_pkg::TCO_BIT_BRK) |=>
			o_break_event ##1 (!o_break_event || $past(sw_break_trigger));
	endproperty
	AST_BREAK_PULSE: assert property (p_break_pulse)
		else $error("Break trigger did not yield a one cycle event.");

	property p_hall_load;
		seq_sw_write(tco_pkg::TCO_BIT_HALL) |=>
			o_hall_event && ctl_reg == $past(ctl_pre);
	endproperty
	AST_HALL_LOAD: assert property (p_hall_load)
		else $error("Commutation event did not load active controls.");

	property p_ch1_flag;
		seq_sw_write(tco_pkg::TCO_BIT_CH1) |=>
			o_channel_one_event && flag_reg[1];
	endproperty
	AST_CH1_FLAG: assert property (p_ch1_flag)
		else $error("Channel trigger did not set event and flag.");

	property p_ovf_event;
		seq_sw_write(tco_pkg::TCO_BIT_OVF) |=>
			o_overflow_event;
	endproperty
	AST_OVF_EVENT: assert property (p_ovf_event)
		else $error("Overflow trigger gave no overflow event.");

	property p_input_hold;
		!out_mode |=> $stable(raw_reg);
	endproperty
	AST_INPUT_HOLD: assert property (p_input_hold)
		else $error("Raw signal moved while channel is an input.");

	property p_forced;
		out_mode && ctl_reg.obs[2:1] == 2'b10 |=> raw_reg == $past(ctl_reg.obs[0]);
	endproperty
	AST_FORCED: assert property (p_forced)
		else $error("Forced level not applied.");

	property p_match_set;
		seq_match_out and (ctl_reg.obs == tco_pkg::TCO_OBS_SET) |=> raw_reg;
	endproperty
	AST_MATCH_SET: assert property (p_match_set)
		else $error("Set on match failed.");

	property p_match_tog;
		seq_match_out and (ctl_reg.obs == tco_pkg::TCO_OBS_TOG) |=> raw_reg != $past(raw_reg);
	endproperty
	AST_MATCH_TOG: assert property (p_match_tog)
		else $error("Toggle on match failed.");

	property p_pwm_a;
		out_mode && ctl_reg.obs == tco_pkg::TCO_OBS_PWMA && !fast_hit |=> raw_reg == $past(pwm_a);
	endproperty
	AST_PWM_A: assert property (p_pwm_a)
		else $error("PWM A level wrong.");

	property p_pwm_b;
		out_mode && ctl_reg.obs == tco_pkg::TCO_OBS_PWMB && !fast_hit |=> raw_reg == !$past(pwm_a);
	endproperty
	AST_PWM_B: assert property (p_pwm_b)
		else $error("PWM B level wrong.");

	property p_out_follow;
		ctl_reg.en && !obs_off |=> o_channel_one_output == ($past(raw_reg) ^ $past(pol));
	endproperty
	AST_OUT_FOLLOW: assert property (p_out_follow)
		else $error("Output does not follow raw with polarity.");

	property p_cmp_direct;
		cmp_write && !compare_shadow_enable |=> cmp_act_reg == $past(i_pwdata[15:0]);
	endproperty
	AST_CMP_DIRECT: assert property (p_cmp_direct)
		else $error("Unbuffered compare write not applied.");

	property p_cmp_shadow;
		compare_shadow_enable && !ovf_evt |=> $stable(cmp_act_reg);
	endproperty
	AST_CMP_SHADOW: assert property (p_cmp_shadow)
		else $error("Active compare changed without overflow.");

	property p_fast_out;
		out_mode && fast_hit && ctl_reg.obs == tco_pkg::TCO_OBS_PWMA |=> raw_reg;
	endproperty
	AST_FAST_OUT: assert property (p_fast_out)
		else $error("Fast output did not act on trigger.");

	property p_flag_sticky;
		seq_match_out |=> flag_reg[1] ##1 (flag_reg[1] || $past(stat_wr));
	endproperty
	AST_FLAG_STICKY: assert property (p_flag_sticky)
		else $error("Compare event did not set channel flag.");

	property p_sw_read_zero;
		take && !i_pwrite && sel_swevt |=> o_pready && o_prdata == 32'h00000000;
	endproperty
	AST_SW_READ_ZERO: assert property (p_sw_read_zero)
		else $error("Trigger register read was not zero.");

	property p_off_rest;
		ctl_reg.en && obs_off |=> o_channel_one_output == $past(pol);
	endproperty
	AST_OFF_REST: assert property (p_off_rest)
		else $error("Disconnected output not at inactive level.");
endmodule

// ### tb_tco_channel.sv
// Self-checking testbench for the channel one compare block.
`timescale 1ns/100ps
module tb_tco_channel;
	logic        i_clk_sys = 1'b0;
	logic        i_resetn = 1'b0;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0;
	logic [15:0] i_counter_value = 16'hFFFF;
	logic        i_count_direction = 1'b0;
	logic        i_overflow_event = 1'b0;
	logic        i_trigger_event = 1'b0;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic        o_channel_one_output;
	logic        o_channel_one_comp_output;
	logic        o_raw_compare_signal;
	logic        o_break_event;
	logic        o_hall_event;
	logic        o_overflow_event;
	logic        o_channel_one_event;
	logic [32:0] rd_q[$];
	logic [3:0]  ev_q[$];
	logic        watch = 1'b0;
	logic [15:0] cv;
	int          mismatches = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          seed = 41691;
	wire  [3:0]  ev = {o_break_event, o_hall_event, o_overflow_event, o_channel_one_event};
	localparam logic [7:0] A_SW = tco_pkg::TCO_ADDR_SWEVT;
	localparam logic [7:0] A_MD = tco_pkg::TCO_ADDR_MODE;
	localparam logic [7:0] A_PL = tco_pkg::TCO_ADDR_POL;
	localparam logic [7:0] A_CP = tco_pkg::TCO_ADDR_CMP;
	localparam logic [7:0] A_BF = tco_pkg::TCO_ADDR_BUF;
	localparam logic [7:0] A_ST = tco_pkg::TCO_ADDR_STAT;
	localparam int         BITS [4] = '{7, 5, 1, 0};
	localparam logic [3:0] CODES [4] = '{4'h8, 4'h4, 4'h1, 4'h2};

	tco_channel DUT (
		.i_clk_sys, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
		.o_prdata, .o_pready, .o_pslverr, .i_counter_value, .i_count_direction,
		.i_overflow_event, .i_trigger_event, .o_channel_one_output,
		.o_channel_one_comp_output, .o_raw_compare_signal, .o_break_event,
		.o_hall_event, .o_overflow_event, .o_channel_one_event
	);

	always #4 i_clk_sys = ~i_clk_sys;

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end

	// Watches answers and event pulses and compares them with the oldest note.
	always @(posedge i_clk_sys) begin
		if (o_pready === 1'b1) begin
			if (rd_q.size() == 0)
				check({o_pslverr, o_prdata}, 33'h1FFFFFFFF);
			else
				check({o_pslverr, o_prdata}, rd_q.pop_front());
		end
		if (watch && (|ev)) begin
			if (ev_q.size() == 0)
				check(ev, 4'h0);
			else
				check(ev, ev_q.pop_front());
		end
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] e);
		rd_q.push_back(e);
		@(posedge i_clk_sys);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk_sys);
		i_penable <= 1'b1;
		@(posedge i_clk_sys);
		while (o_pready !== 1'b1) @(posedge i_clk_sys);
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask

	task automatic mode(input logic [7:0] m);
		wr(A_MD, {24'h0, m});
	endtask

	task automatic lvl(input logic r, input logic o);
		repeat (3) @(posedge i_clk_sys);
		#1;
		check(o_raw_compare_signal, r);
		check(o_channel_one_output, o);
	endtask

	task automatic hit();
		@(posedge i_clk_sys);
		i_counter_value <= cv;
		@(posedge i_clk_sys);
		i_counter_value <= cv + 16'h0008;
	endtask

	initial begin
		cv = {2'b01, 14'($random(seed))};
		repeat (20) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		rd(A_MD, 32'h0);
		rd(A_PL, 32'h0);
		rd(A_CP, 32'h0);
		rd(A_BF, 32'h0);
		rd(A_ST, 32'h0);
		apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 8'h1C, 32'hFFFF, {1'b1, 32'h0});
		wr(A_MD, 32'hFF);
		rd(A_MD, 32'h7F);
		wr(A_MD, 32'h0);
		$display("test registers done");
		watch <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			ev_q.push_back(CODES[i]);
			wr(A_SW, 32'h1 << BITS[i]);
			repeat (3) @(posedge i_clk_sys);
		end
		wr(A_SW, 32'hFF5C);
		repeat (3) @(posedge i_clk_sys);
		rd(A_SW, 32'h0);
		rd(A_ST, 32'hA3);
		wr(A_ST, 32'h0);
		rd(A_ST, 32'h0);
		watch <= 1'b0;
		check(ev_q.size(), 33'h0);
		$display("test triggers done");
		wr(A_PL, 32'h1);
		wr(A_CP, {16'h0, cv});
		rd(A_CP, {16'h0, cv});
		mode(8'h10);
		hit();
		lvl(1'b1, 1'b1);
		rd(A_ST, 32'h2);
		mode(8'h20);
		hit();
		lvl(1'b0, 1'b0);
		mode(8'h30);
		hit();
		lvl(1'b1, 1'b1);
		hit();
		lvl(1'b0, 1'b0);
		mode(8'h50);
		lvl(1'b1, 1'b1);
		mode(8'h40);
		lvl(1'b0, 1'b0);
		for (int k = 0; k < 8; k++) begin
			i_count_direction <= k[0];
			i_counter_value <= k[1] ? cv + 16'h1 : cv - 16'h1;
			mode(k[2] ? 8'h70 : 8'h60);
			lvl(k[2] ^ !k[1], k[2] ^ !k[1]);
		end
		wr(A_PL, 32'h3);
		mode(8'h50);
		lvl(1'b1, 1'b0);
		mode(8'h00);
		lvl(1'b1, 1'b1);
		wr(A_PL, 32'h5);
		mode(8'h40);
		lvl(1'b0, 1'b0);
		check(o_channel_one_comp_output, 1'b1);
		wr(A_PL, 32'h1);
		$display("test compare modes done");
		mode(8'h08);
		wr(A_CP, {16'h0, ~cv});
		rd(A_CP, {16'h0, cv});
		@(posedge i_clk_sys);
		i_overflow_event <= 1'b1;
		@(posedge i_clk_sys);
		i_overflow_event <= 1'b0;
		rd(A_CP, {16'h0, ~cv});
		mode(8'h00);
		wr(A_CP, {16'h0, cv});
		rd(A_CP, {16'h0, cv});
		$display("test shadow done");
		i_count_direction <= 1'b0;
		i_counter_value <= cv + 16'h1;
		for (int k = 0; k < 4; k++) begin
			mode(8'h60 | (k[0] ? 8'h10 : 8'h00) | (k[1] ? 8'h04 : 8'h00));
			lvl(k[0], k[0]);
			@(posedge i_clk_sys);
			i_trigger_event <= 1'b1;
			@(posedge i_clk_sys);
			i_trigger_event <= 1'b0;
			#1;
			check(o_raw_compare_signal, k[0] ^ k[1]);
		end
		$display("test fast output done");
		mode(8'h40);
		lvl(1'b0, 1'b0);
		wr(A_BF, 32'h1);
		mode(8'h50);
		lvl(1'b0, 1'b0);
		wr(A_SW, 32'h20);
		lvl(1'b1, 1'b1);
		$display("test commutation done");
		results();
	end
endmodule
